// *** eea_pkg.sv ***
`default_nettype none
package eea_pkg;
  // ----------------------------------------
  // Frame content
  // ----------------------------------------
  localparam logic [7:0] EEA_CMD_READ = 8'h0D;
  localparam logic [7:0] EEA_CMD_WRITE = 8'h06;
  localparam logic [7:0] EEA_CRC_INIT = 8'h00;
  localparam logic [7:0] EEA_DATA_BUSY = 8'h00;
  localparam int EEA_BUSY_BIT = 0;
  localparam int EEA_ADDR_MSB = 7;
  localparam int EEA_ADDR_LSB = 1;
  localparam logic [1:0] EEA_RD_FIELDS = 2'h2;
  localparam logic [1:0] EEA_WR_FIELDS = 2'h3;
  localparam logic [1:0] EEA_RSP_FIELDS = 2'h3;
  localparam logic [5:0] EEA_RD_BITS = 6'h18;
  localparam logic [5:0] EEA_WR_BITS = 6'h20;
  localparam logic [4:0] EEA_RSP_LAST_BIT = 5'h1F;
  localparam int EEA_MEM_WORDS = 128;
  // ----------------------------------------
  // Timing and buffering
  // ----------------------------------------
  localparam int EEA_CLK_MHZ = 100;
  localparam int EEA_WR_TIME_US = 5;
  localparam int EEA_WR_CYCLES = EEA_WR_TIME_US * EEA_CLK_MHZ;
  localparam int EEA_FIFO_WIDTH = 9;
  localparam int EEA_FIFO_DEPTH = 16;
  // ----------------------------------------
  // Check value: one shift step per link bit
  // ----------------------------------------
  function automatic logic [7:0] eea_crc_bit(input logic [7:0] c, input logic b);
    eea_crc_bit = {c[6:0], b ^ c[7]};
  endfunction
  function automatic logic [7:0] eea_crc_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = eea_crc_bit(r, d[i]);
    end
    eea_crc_byte = r;
  endfunction
endpackage
`default_nettype wire

// *** eea_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface eea_link_if;
  // Master to encoder
  logic m2e_bit;
  logic m2e_vld;
  logic m2e_frm;
  // Encoder to master
  logic e2m_bit;
  logic e2m_vld;
  logic e2m_frm;
  modport dev (
    input m2e_bit, m2e_vld, m2e_frm,
    output e2m_bit, e2m_vld, e2m_frm
  );
  modport mst (
    output m2e_bit, m2e_vld, m2e_frm,
    input e2m_bit, e2m_vld, e2m_frm
  );
endinterface
`default_nettype wire

// *** eea_encoder_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Encoder end
// ----------------------------------------
module eea_encoder_end
  import eea_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Link
  eea_link_if.dev link,
  // Status
  output logic mem_busy_o,
  output logic crc_err_o,
  output logic req_drop_o
);
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b01,
    GEN_PUSH = 2'b10
  } eea_gen_t;
  // ----------------------------------------
  // Request receiver
  // ----------------------------------------
  logic [4:0] rx_cnt;
  logic [7:0] rx_sr;
  logic [7:0] rx_crc;
  logic [7:0] rx_cmd;
  logic [7:0] rx_adf;
  logic [7:0] rx_edf;
  logic [1:0] rx_nf;
  logic rx_done;
  logic rx_bit;
  logic byte_done;
  logic covered;
  logic [1:0] fld;
  logic [7:0] byte_val;
  logic frame_ok;
  assign rx_bit = link.m2e_vld & link.m2e_frm & ~rx_done;
  assign fld = rx_cnt[4:3];
  assign byte_done = rx_bit & (rx_cnt[2:0] == 3'h7);
  assign byte_val = {link.m2e_bit, rx_sr[7:1]};
  // Command byte is always covered; later ones only below the check field
  assign covered = (fld == 2'h0) | (fld < rx_nf);
  assign frame_ok = byte_done & (fld != 2'h0) & (fld == rx_nf) & (byte_val == rx_crc);
  always_ff @(posedge mclk_i) begin
    if (srst_i | ~link.m2e_frm) begin
      rx_cnt <= '0;
      rx_crc <= EEA_CRC_INIT;
      rx_done <= 1'b0;
    end else if (rx_bit) begin
      rx_cnt <= rx_cnt + 1'b1;
      if (covered) begin
        rx_crc <= eea_crc_bit(rx_crc, link.m2e_bit);
      end
      if (byte_done & ((fld == 2'h0) ? (byte_val != EEA_CMD_READ &&
          byte_val != EEA_CMD_WRITE) : (fld == rx_nf))) begin
        rx_done <= 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_sr <= '0;
    end else if (rx_bit) begin
      rx_sr <= byte_val;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_cmd <= '0;
      rx_adf <= '0;
      rx_edf <= '0;
      rx_nf <= '0;
    end else if (byte_done) begin
      case (fld)
        2'h0: begin
          rx_cmd <= byte_val;
          rx_nf <= (byte_val == EEA_CMD_WRITE) ? EEA_WR_FIELDS : EEA_RD_FIELDS;
        end
        2'h1: rx_adf <= byte_val;
        2'h2: rx_edf <= byte_val;
        default: ;
      endcase
    end
  end
  // A frame whose check byte mismatches gets no reply at all
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      crc_err_o <= 1'b0;
    end else begin
      crc_err_o <= byte_done & (fld != 2'h0) & (fld == rx_nf) & (byte_val != rx_crc);
    end
  end
  // ----------------------------------------
  // Nonvolatile store and write engine
  // ----------------------------------------
  logic [7:0] mem [EEA_MEM_WORDS];
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [$clog2(EEA_WR_CYCLES)-1:0] wr_cnt;
  logic wr_busy;
  logic wr_accept;
  logic gen_free;
  eea_gen_t gen_state;
  logic [6:0] req_addr;
  assign req_addr = rx_adf[EEA_ADDR_MSB:EEA_ADDR_LSB];
  assign gen_free = gen_state == GEN_IDLE;
  assign wr_accept = frame_ok & gen_free & (rx_cmd == EEA_CMD_WRITE) & ~wr_busy;
  assign mem_busy_o = wr_busy;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_busy <= 1'b0;
      wr_cnt <= '0;
      wr_addr <= '0;
      wr_data <= '0;
    end else if (wr_accept) begin
      wr_busy <= 1'b1;
      wr_cnt <= ($clog2(EEA_WR_CYCLES))'(EEA_WR_CYCLES - 1);
      wr_addr <= req_addr;
      wr_data <= rx_edf;
    end else if (wr_busy) begin
      if (wr_cnt == '0) begin
        wr_busy <= 1'b0;
      end else begin
        wr_cnt <= wr_cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < EEA_MEM_WORDS; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_busy & (wr_cnt == '0)) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // ----------------------------------------
  // Reply generator
  // ----------------------------------------
  logic [1:0] gen_idx;
  logic [7:0] gen_adf;
  logic [7:0] gen_edf;
  logic [7:0] gen_cmd;
  logic [7:0] gen_crc;
  logic [7:0] gen_byte;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [EEA_FIFO_WIDTH-1:0] fifo_out_data;
  always_comb begin
    case (gen_idx)
      2'h0: gen_byte = gen_cmd;
      2'h1: gen_byte = gen_adf;
      2'h2: gen_byte = gen_edf;
      default: gen_byte = gen_crc;
    endcase
  end
  // Requests arriving while a reply is still being queued are dropped
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      req_drop_o <= 1'b0;
    end else begin
      req_drop_o <= frame_ok & ~gen_free;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      gen_state <= GEN_IDLE;
      gen_idx <= '0;
      gen_cmd <= '0;
      gen_adf <= '0;
      gen_edf <= '0;
      gen_crc <= EEA_CRC_INIT;
    end else begin
      case (gen_state)
        GEN_IDLE: begin
          gen_idx <= '0;
          gen_crc <= EEA_CRC_INIT;
          if (frame_ok) begin
            gen_state <= GEN_PUSH;
            gen_cmd <= rx_cmd;
            gen_adf <= {req_addr, wr_busy};
            if (rx_cmd == EEA_CMD_READ) begin
              gen_edf <= wr_busy ? EEA_DATA_BUSY : mem[req_addr];
            end else begin
              gen_edf <= rx_edf;
            end
          end
        end
        GEN_PUSH: begin
          if (fifo_in_ready) begin
            gen_idx <= gen_idx + 1'b1;
            if (gen_idx < EEA_RSP_FIELDS) begin
              gen_crc <= eea_crc_byte(gen_crc, gen_byte);
            end else begin
              gen_state <= GEN_IDLE;
            end
          end
        end
        default: gen_state <= GEN_IDLE;
      endcase
    end
  end
  eea_fifo #(
    .WIDTH(EEA_FIFO_WIDTH),
    .DEPTH(EEA_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .in_valid_i(gen_state == GEN_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i({gen_idx == EEA_RSP_FIELDS, gen_byte}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );
  // ----------------------------------------
  // Reply serialiser
  // ----------------------------------------
  logic [7:0] tx_sr;
  logic [2:0] tx_left;
  logic tx_last;
  assign fifo_out_ready = ~link.e2m_vld;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_sr <= '0;
      tx_left <= '0;
      tx_last <= 1'b0;
      link.e2m_bit <= 1'b0;
      link.e2m_vld <= 1'b0;
      link.e2m_frm <= 1'b0;
    end else if (fifo_out_valid & fifo_out_ready) begin
      link.e2m_bit <= fifo_out_data[0];
      link.e2m_vld <= 1'b1;
      link.e2m_frm <= 1'b1;
      tx_sr <= {1'b0, fifo_out_data[7:1]};
      tx_left <= 3'h7;
      tx_last <= fifo_out_data[8];
    end else if (link.e2m_vld) begin
      if (tx_left != 3'h0) begin
        link.e2m_bit <= tx_sr[0];
        tx_sr <= {1'b0, tx_sr[7:1]};
        tx_left <= tx_left - 1'b1;
      end else begin
        link.e2m_vld <= 1'b0;
        link.e2m_frm <= ~tx_last;
      end
    end
  end
endmodule
`default_nettype wire

// *** eea_master_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module eea_master_end
  import eea_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Link
  eea_link_if.mst link,
  // Request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [6:0] req_addr_i,
  input wire logic [7:0] req_data_i,
  // Reply
  output logic rsp_valid_o,
  output logic [7:0] rsp_cmd_o,
  output logic [6:0] rsp_addr_o,
  output logic rsp_busy_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_crc_ok_o
);
  // ----------------------------------------
  // Request serialiser
  // ----------------------------------------
  logic [7:0] cmd;
  logic [7:0] adf;
  logic [7:0] crc;
  logic [31:0] frame;
  logic [31:0] tx_sh;
  logic [5:0] tx_left;
  assign req_ready_o = ~link.m2e_frm;
  assign cmd = req_write_i ? EEA_CMD_WRITE : EEA_CMD_READ;
  assign adf = {req_addr_i, 1'b0};
  always_comb begin
    crc = eea_crc_byte(eea_crc_byte(EEA_CRC_INIT, cmd), adf);
    if (req_write_i) begin
      crc = eea_crc_byte(crc, req_data_i);
      frame = {crc, req_data_i, adf, cmd};
    end else begin
      frame = {8'h00, crc, adf, cmd};
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_sh <= '0;
      tx_left <= '0;
      link.m2e_bit <= 1'b0;
      link.m2e_vld <= 1'b0;
      link.m2e_frm <= 1'b0;
    end else if (req_valid_i & req_ready_o) begin
      link.m2e_bit <= frame[0];
      link.m2e_vld <= 1'b1;
      link.m2e_frm <= 1'b1;
      tx_sh <= {1'b0, frame[31:1]};
      tx_left <= (req_write_i ? EEA_WR_BITS : EEA_RD_BITS) - 6'h1;
    end else if (link.m2e_frm) begin
      if (tx_left != 6'h0) begin
        link.m2e_bit <= tx_sh[0];
        tx_sh <= {1'b0, tx_sh[31:1]};
        tx_left <= tx_left - 6'h1;
      end else begin
        // Frame drops for at least one cycle so the encoder restarts its check
        link.m2e_vld <= 1'b0;
        link.m2e_frm <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Reply receiver
  // ----------------------------------------
  logic [4:0] rx_cnt;
  logic [31:0] rx_sh;
  logic [7:0] rx_crc;
  logic rx_bit;
  logic [31:0] rx_next;
  assign rx_bit = link.e2m_vld & link.e2m_frm;
  assign rx_next = {link.e2m_bit, rx_sh[31:1]};
  always_ff @(posedge mclk_i) begin
    if (srst_i | ~link.e2m_frm) begin
      rx_cnt <= '0;
      rx_sh <= '0;
      rx_crc <= EEA_CRC_INIT;
    end else if (rx_bit) begin
      rx_cnt <= rx_cnt + 5'h1;
      rx_sh <= rx_next;
      if (rx_cnt[4:3] != 2'h3) begin
        rx_crc <= eea_crc_bit(rx_crc, link.e2m_bit);
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_cmd_o <= '0;
      rsp_addr_o <= '0;
      rsp_busy_o <= 1'b0;
      rsp_data_o <= '0;
      rsp_crc_ok_o <= 1'b0;
    end else begin
      rsp_valid_o <= rx_bit & (rx_cnt == EEA_RSP_LAST_BIT);
      if (rx_bit & (rx_cnt == EEA_RSP_LAST_BIT)) begin
        rsp_cmd_o <= rx_next[7:0];
        rsp_addr_o <= rx_next[8+EEA_ADDR_MSB:8+EEA_ADDR_LSB];
        rsp_busy_o <= rx_next[8+EEA_BUSY_BIT];
        rsp_data_o <= rx_next[23:16];
        rsp_crc_ok_o <= rx_next[31:24] == rx_crc;
      end
    end
  end
endmodule
// ----------------------------------------
// Reply byte buffer
// ----------------------------------------
module eea_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** eea_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module eea_link_props
  import eea_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Link
  input wire logic m2e_vld,
  input wire logic m2e_frm,
  input wire logic e2m_vld,
  input wire logic e2m_frm,
  // Status
  input wire logic mem_busy_o
);
  // ----------------------------------------
  // Busy length counter
  // ----------------------------------------
  logic [9:0] busy_cnt;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_cnt <= 10'h000;
    end else begin
      busy_cnt <= mem_busy_o ? busy_cnt + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst_idle;
    $fell(srst_i) |-> !e2m_frm && !e2m_vld && !mem_busy_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
  property p_req_bits;
    $rose(m2e_frm) |-> m2e_vld[*8] ##1 m2e_vld[*8] ##1 m2e_vld[*8];
  endproperty
  a_req_bits: assert property (p_req_bits) else $error("request bits not contiguous");
  property p_req_qual;
    m2e_vld |-> m2e_frm;
  endproperty
  a_req_qual: assert property (p_req_qual) else $error("request bit outside frame");
  property p_rsp_qual;
    e2m_vld |-> e2m_frm;
  endproperty
  a_rsp_qual: assert property (p_rsp_qual) else $error("reply bit outside frame");
  property p_rsp_byte;
    $rose(e2m_frm) |-> e2m_vld[*8] ##1 (e2m_frm && !e2m_vld) ##1 e2m_vld[*8];
  endproperty
  a_rsp_byte: assert property (p_rsp_byte) else $error("reply byte not eight bits");
  property p_rsp_len;
    $rose(e2m_frm) |-> ##34 (e2m_frm && e2m_vld) ##1 !e2m_frm;
  endproperty
  a_rsp_len: assert property (p_rsp_len) else $error("reply frame length wrong");
  property p_busy_hold;
    $rose(mem_busy_o) |-> mem_busy_o[*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_busy_len;
    $fell(mem_busy_o) |-> busy_cnt == 10'(EEA_WR_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  c_write_busy: cover property ($rose(mem_busy_o));
  c_reply: cover property ($rose(e2m_frm));
  c_commit: cover property ($fell(mem_busy_o));
endmodule
`default_nettype wire

// *** tb_encoder_eeprom_access_crc.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_eeprom_access_crc
  import eea_pkg::*;
;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_valid_i, req_ready_o, req_write_i, rsp_valid_o, rsp_busy_o, rsp_crc_ok_o;
  logic [6:0] req_addr_i, rsp_addr_o, a;
  logic [7:0] req_data_i, rsp_cmd_o, rsp_data_o, d;
  logic busy_a, err_a, drop_a, busy_b, err_b, drop_b;
  logic [31:0] cap_a, cap_b, fr;
  logic [7:0] exp_mem [128];
  int failures, check_count, n, m, q;
  always #5 mclk_i = ~mclk_i;
  eea_link_if link_a ();
  eea_link_if link_b ();
  eea_master_end eea_master_end_i (.mclk_i(mclk_i), .srst_i(srst_i), .link(link_a),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_data_i(req_data_i), .rsp_valid_o(rsp_valid_o),
    .rsp_cmd_o(rsp_cmd_o), .rsp_addr_o(rsp_addr_o), .rsp_busy_o(rsp_busy_o),
    .rsp_data_o(rsp_data_o), .rsp_crc_ok_o(rsp_crc_ok_o));
  eea_encoder_end eea_encoder_end_i (.mclk_i(mclk_i), .srst_i(srst_i), .link(link_a),
    .mem_busy_o(busy_a), .crc_err_o(err_a), .req_drop_o(drop_a));
  eea_encoder_end eea_encoder_end_b_i (.mclk_i(mclk_i), .srst_i(srst_i), .link(link_b),
    .mem_busy_o(busy_b), .crc_err_o(err_b), .req_drop_o(drop_b));
  eea_link_props eea_link_props_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .m2e_vld(link_a.m2e_vld), .m2e_frm(link_a.m2e_frm), .e2m_vld(link_a.e2m_vld),
    .e2m_frm(link_a.e2m_frm), .mem_busy_o(busy_a));
  // ----------------------------------------
  // Reply capture, bits arrive LSB first
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (link_a.e2m_frm && link_a.e2m_vld) cap_a <= {link_a.e2m_bit, cap_a[31:1]};
    if (link_b.e2m_frm && link_b.e2m_vld) cap_b <= {link_b.e2m_bit, cap_b[31:1]};
  end
  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic logic [7:0] crc8(input logic [31:0] v, input int nb);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < nb; i++) begin
      c = {c[6:0], v[i] ^ c[7]};
    end
    return c;
  endfunction
  function automatic logic [7:0] exp_data(input logic wr, input logic bz, input logic [6:0] ea,
      input logic [7:0] ed);
    if (wr) return ed;
    return bz ? 8'h00 : exp_mem[ea];
  endfunction
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      failures++;
      tally_and_finish;
    end
  endtask
  task automatic do_req(input logic wr, input logic [6:0] ra, input logic [7:0] rd,
      input logic bz);
    logic [7:0] cmd;
    int k;
    cmd = wr ? EEA_CMD_WRITE : EEA_CMD_READ;
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= ra;
    req_data_i <= rd;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (req_ready_o !== 1'b1 && k < 100);
    tmo(k, 100);
    req_valid_i <= 1'b0;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (rsp_valid_o !== 1'b1 && k < 200);
    tmo(k, 200);
    chk(9'(rsp_cmd_o), 9'(cmd));
    chk(9'(rsp_addr_o), 9'(ra));
    chk(9'(rsp_busy_o), 9'(bz));
    chk(9'(rsp_data_o), 9'(exp_data(wr, bz, ra, rd)));
    chk(9'(rsp_crc_ok_o), 9'h001);
    chk(9'(cap_a[15:8]), 9'({ra, bz}));
    chk(9'(cap_a[31:24]), 9'(crc8(cap_a, 24)));
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {req_valid_i, req_write_i, req_addr_i, req_data_i} <= '0;
    {link_b.m2e_bit, link_b.m2e_vld, link_b.m2e_frm} = 3'h0;
    failures = 0;
    check_count = 0;
    foreach (exp_mem[i]) exp_mem[i] = 8'h00;
    void'($urandom(32'hFEC6));
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    chk(9'(busy_a), 9'h000);
    do_req(1'b0, 7'h00, 8'h00, 1'b0);
    do_req(1'b0, 7'h7F, 8'h00, 1'b0);
    $display("test read_idle done");
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 7'h7F : 7'($urandom);
      d = 8'($urandom);
      do_req(1'b1, a, d, 1'b0);
      chk(9'(busy_a), 9'h001);
      do_req(1'b0, a, 8'h00, 1'b1);
      do_req(1'b1, a + 7'h01, ~d, 1'b1);
      n = 0;
      while (busy_a === 1'b1 && n < 600) begin @(posedge mclk_i); n++; end
      tmo(n, 600);
      exp_mem[a] = d;
      do_req(1'b0, a, 8'h00, 1'b0);
      do_req(1'b0, a + 7'h01, 8'h00, 1'b0);
    end
    $display("test write_busy done");
    // Far encoder: bad check byte, unknown command, then a read with the busy bit set
    for (int k = 0; k < 3; k++) begin
      a = 7'($urandom);
      fr = {8'h00, a, k == 2, (k == 1) ? (EEA_CMD_READ ^ 8'h10) : EEA_CMD_READ};
      fr[23:16] = crc8(fr, 16) ^ {7'h00, k == 0};
      for (int i = 0; i < 24; i++) begin
        link_b.m2e_frm <= 1'b1;
        link_b.m2e_vld <= 1'b1;
        link_b.m2e_bit <= fr[i];
        @(posedge mclk_i);
      end
      link_b.m2e_frm <= 1'b0;
      link_b.m2e_vld <= 1'b0;
      link_b.m2e_bit <= ~fr[23];
      n = 0;
      m = 0;
      q = 0;
      repeat (50) begin
        @(posedge mclk_i);
        if (err_b === 1'b1) n++;
        if (link_b.e2m_frm === 1'b1) m = 1;
        if (drop_b === 1'b1 || busy_b === 1'b1) q++;
      end
      chk(9'(n), 9'(k == 0));
      chk(9'(m), 9'(k == 2));
      chk(9'(q), 9'h000);
    end
    chk(9'(cap_b[15:8]), 9'({a, 1'b0}));
    chk(9'(cap_b[23:16]), 9'h000);
    chk(9'(cap_b[31:24]), 9'(crc8(cap_b, 24)));
    $display("test far_end done");
    // Burst: back-to-back reads queue their replies in the encoder's buffer
    a = 7'($urandom);
    req_write_i <= 1'b0;
    req_addr_i <= a;
    req_valid_i <= 1'b1;
    n = 0;
    m = 0;
    q = 0;
    for (int t = 0; t < 400 && m < 3; t++) begin
      @(posedge mclk_i);
      if (req_valid_i === 1'b1 && req_ready_o === 1'b1) begin
        n++;
        if (n == 3) req_valid_i <= 1'b0;
      end
      if (err_a === 1'b1 || drop_a === 1'b1) q++;
      if (rsp_valid_o === 1'b1) begin
        m++;
        chk(9'(rsp_addr_o), 9'(a));
        chk(9'(rsp_data_o), 9'(exp_mem[a]));
        chk(9'(rsp_crc_ok_o), 9'h001);
      end
    end
    chk(9'(n), 9'h003);
    chk(9'(m), 9'h003);
    chk(9'(q), 9'h000);
    $display("test burst done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
